// file: bench/mbr_frame_handler_tb.sv
/*
 * Self-checking bench of the frame handler: frames, answers, register writes.
 * Assumes the host model and a combinational register file model.
 */
`default_nettype none
module mbr_frame_handler_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
    logic clk_in = 0, rst_b_in = 0, remote_in = 0, stall = 0;
    logic rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
    logic text_valid_out, reg_wr_out, reg_coil_out, coil_state_in;
    logic [7:0] rx_data_in, tx_data_out, text_data_out, eb, tb_t;
    logic [15:0] reg_addr_out, reg_wdata_out, reg_rdata_in;
    logic [32:0] wb;
    logic [7:0] exp_q[$], tq[$];
    logic [32:0] wq[$];
    int n_mismatch = 0, checked = 0;
    // =========================================================
    // design, partner and register file
    initial forever #4 clk_in = ~clk_in;
    assign reg_rdata_in  = reg_addr_out ^ 16'h5A5A;
    assign coil_state_in = reg_addr_out[0];
    mbr_frame_handler DUT (.clk_in, .rst_b_in, .rx_valid_in, .rx_data_in, .rx_ready_out,
        .tx_valid_out, .tx_data_out, .tx_ready_in, .text_valid_out, .text_data_out,
        .reg_addr_out, .reg_wdata_out, .reg_wr_out, .reg_coil_out, .reg_rdata_in,
        .coil_state_in, .remote_in);
    mbr_host_model host (.clk_in, .rx_ready_in(rx_ready_out), .stall_in(stall),
        .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in), .tx_ready_out(tx_ready_in));
    // =========================================================
    // checking
    // sampled away from the launching edge
    always @(negedge clk_in) begin
        if (tx_valid_out && tx_ready_in) begin eb = exp_q.pop_front();
            `CHK(tx_data_out, eb) end
        if (reg_wr_out) begin wb = wq.pop_front();
            `CHK({reg_coil_out, reg_addr_out, reg_wdata_out}, wb) end
        if (text_valid_out) begin tb_t = tq.pop_front(); `CHK(text_data_out, tb_t) end
    end
    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    task automatic run(input logic [7:0] p[$], input logic [7:0] e[$], input bit bad);
        logic [15:0] c;
        p.push_front(8'h00);
        e.push_front(8'h00);
        c = crc(p);
        p.push_back(c[7:0] ^ 8'(bad));
        p.push_back(c[15:8]);
        c = crc(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        foreach (e[i]) exp_q.push_back(e[i]);
        host.send(p);
    endtask
    task automatic results;
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic timeout;
        n_mismatch++;
        results();
    endtask
    // =========================================================
    // scenarios
    initial begin
        logic [15:0] a, v;
        logic [7:0] e[$];
        void'($urandom(32'hA837));
        repeat (4) @(posedge clk_in);
        #1 rst_b_in = 1;
        run('{8'h03, 8'h00, 8'h10, 8'h00, 8'h02}, '{8'h03, 8'h04, 8'h5A, 8'h4A, 8'h5A, 8'h4B}, 0);
        run('{8'h01, 8'h00, 8'h21, 8'h00, 8'h01}, '{8'h01, 8'h02, 8'hFF, 8'h00}, 0);
        run('{8'h06, 8'h00, 8'h12, 8'hBE, 8'hEF}, '{8'h86, 8'h07}, 0);
        repeat (20) @(posedge clk_in);
        #1 remote_in = 1;
        wq = '{33'h00012BEEF, 33'h100210000, 33'h000401122, 33'h000413344};
        run('{8'h06, 8'h00, 8'h12, 8'hBE, 8'hEF}, '{8'h06, 8'h00, 8'h12, 8'hBE, 8'hEF}, 0);
        run('{8'h05, 8'h00, 8'h21, 8'h00, 8'h00}, '{8'h05, 8'h00, 8'h21, 8'h00, 8'h00}, 0);
        run('{8'h05, 8'h00, 8'h21, 8'h12, 8'h34}, '{8'h85, 8'h03}, 0);
        run('{8'h03, 8'h00, 8'h10, 8'h00, 8'h02}, '{8'h83, 8'h05}, 1);
        run('{8'h07, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h87, 8'h01}, 0);
        run('{8'h10, 8'h00, 8'h40, 8'h00, 8'h02, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44},
            '{8'h10, 8'h00, 8'h40, 8'h00, 8'h02}, 0);
        a = 16'($urandom());
        v = 16'($urandom());
        wq.push_back({1'b0, a, v});
        e = '{8'h06, a[15:8], a[7:0], v[15:8], v[7:0]};
        run(e, e, 0);
        tq = '{8'h41, 8'h0A};
        host.send('{8'h41, 8'h0A});
        e = '{8'h03, 8'h10};
        for (int i = 0; i < 8; i++) begin e.push_back(8'h5A); e.push_back(8'h5A ^ 8'(i)); end
        stall = 1;
        run('{8'h03, 8'h00, 8'h00, 8'h00, 8'h08}, e, 0);
        repeat (60) @(posedge clk_in);
        #1 stall = 0;
        for (int k = 0; k < 500 && exp_q.size() > 0; k++) @(posedge clk_in);
        if (exp_q.size() + wq.size() + tq.size() > 0) n_mismatch++;
        results();
    end
endmodule // mbr_frame_handler_tb
`default_nettype wire

// file: bench/mbr_host_model.sv
/*
 * Host partner: sends request bytes with valid/ready and sinks answer bytes.
 * Assumes the testbench top is mbr_frame_handler_tb and owns the timeout task.
 */
`default_nettype none
module mbr_host_model (
    input  wire logic       clk_in,
    input  wire logic       rx_ready_in,
    input  wire logic       stall_in,
    output logic            rx_valid_out,
    output logic      [7:0] rx_data_out,
    output logic            tx_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // link driver
    initial begin
        rx_valid_out = 1'b0;
        rx_data_out  = 8'hA5;
        tx_ready_out = 1'b1;
    end
    // stalling the sink lets the answer FIFO fill up
    always @(posedge clk_in) tx_ready_out <= #1 !stall_in;
    task automatic send(input logic [7:0] q[$]);
        int k;
        @(posedge clk_in);
        #1;
        foreach (q[i]) begin
            rx_valid_out = 1'b1;
            rx_data_out  = q[i];
            k = 0;
            // ready is a register: its value at the falling edge is what gets sampled
            do begin @(negedge clk_in); k++; end while (!rx_ready_in && k < 2000);
            if (k >= 2000) mbr_frame_handler_tb.timeout();
            @(posedge clk_in);
            #1;
        end
        rx_valid_out = 1'b0;
        rx_data_out  = ~rx_data_out; // released line shows no stale byte
    endtask
endmodule // mbr_host_model
`default_nettype wire

// file: rtl/mbr_crc.sv
/*
 * Running reflected 16-bit frame checksum, one byte per clock.
 * Assumes init and enable are never wanted together in the same byte.
 */
`include "mbr_regs.svh"
`default_nettype none
module mbr_crc (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // byte feed
    input  wire logic        init_in,
    input  wire logic        en_in,
    input  wire logic [7:0]  data_in,
    // result
    output logic      [15:0] crc_out
);
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MBR_CRC_POLY) : (r >> 1); // RL16
        end
        return r;
    endfunction

    always_comb begin
        crc_nxt = crc_r;
        if (init_in) begin
            crc_nxt = crc_step(`MBR_CRC_INIT, data_in); // RL16
        end else if (en_in) begin
            crc_nxt = crc_step(crc_r, data_in);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            crc_r <= `MBR_CRC_INIT;
        end else begin
            crc_r <= crc_nxt;
        end
    end

    assign crc_out = crc_r;
endmodule // mbr_crc
`default_nettype wire

// file: rtl/mbr_fifo.sv
/*
 * Response FIFO between the frame handler and the outgoing link.
 * Assumes D is a power of two so the pointers wrap by themselves.
 */
`default_nettype none
module mbr_fifo #(
    parameter int W  = 8,
    parameter int D  = 16,
    parameter int AW = $clog2(D)
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // fill and drain sides
    mbr_strm_if.snk   in_if,
    mbr_strm_if.src   out_if
);
    localparam logic [AW:0] FULL = (AW + 1)'(D);

    logic [W-1:0]  mem [0:D-1];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop, vld_r, vld_nxt;

    assign in_if.ready  = (cnt_r != FULL);
    assign out_if.valid = vld_r;
    assign out_if.data  = mem[rp_r];
    assign push         = in_if.valid && in_if.ready;
    assign pop          = out_if.valid && out_if.ready;

    always_comb begin
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        vld_nxt = (cnt_nxt != '0);
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            vld_r <= 1'b0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            vld_r <= vld_nxt;
        end
    end

    // storage has no reset; empty flag guards stale words
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp_r] <= in_if.data;
        end
    end
endmodule // mbr_fifo
`default_nettype wire

// file: rtl/mbr_frame_handler.sv
/*
 * Slave-side handler for binary register frames sharing a byte link with
 * text commands: separates the two, checks length and checksum, performs
 * register and coil accesses and queues the answer frame.
 * Assumes the text interpreter takes one byte per cycle without stalling and
 * the instrument answers reg_rdata_in and coil_state_in in the same cycle in which
 * reg_addr_out changes.
 */
`include "mbr_regs.svh"
`default_nettype none
module mbr_frame_handler
    import mbr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // incoming link bytes
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_data_in,
    output logic             rx_ready_out,
    // outgoing link bytes
    output logic             tx_valid_out,
    output logic      [7:0]  tx_data_out,
    input  wire logic        tx_ready_in,
    // text interpreter
    output logic             text_valid_out,
    output logic      [7:0]  text_data_out,
    // instrument registers
    output logic      [15:0] reg_addr_out,
    output logic      [15:0] reg_wdata_out,
    output logic             reg_wr_out,
    output logic             reg_coil_out,
    input  wire logic [15:0] reg_rdata_in,
    input  wire logic        coil_state_in,
    input  wire logic        remote_in
);
    // =====================================================================
    // state
    mbr_state_type state_r, state_nxt;
    logic [7:0]    buf_mem [0:`MBR_BUF_DEPTH-1];
    logic [8:0]    idx_r, idx_nxt, len_r, len_nxt;
    logic [8:0]    tidx_r, tidx_nxt, tlen_r, tlen_nxt;
    logic [7:0]    err_r, err_nxt, k_r, k_nxt;
    logic          ph_r, ph_nxt;
    logic          rx_ready_r, rx_ready_nxt;
    logic          text_valid_r, text_valid_nxt;
    logic [7:0]    text_data_r, text_data_nxt;
    logic [15:0]   reg_addr_r, reg_addr_nxt, reg_wdata_r, reg_wdata_nxt;
    logic          reg_wr_r, reg_wr_nxt, reg_coil_r, reg_coil_nxt;

    logic          rx_take, push_fire;
    logic          rx_crc_init, rx_crc_en, tx_crc_init, tx_crc_en;
    logic [15:0]   rx_crc, tx_crc;
    logic [7:0]    fc, cnt, exec_err, tx_byte;
    logic [15:0]   start, num;
    logic          crc_ok, fc_ok, is_wr;

    mbr_strm_if #(.W(8)) push_if ();
    mbr_strm_if #(.W(8)) pop_if ();

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // multi-byte fields arrive high byte first
    function automatic logic [15:0] word_at(input logic [8:0] i);
        return {buf_mem[i], buf_mem[i + 9'h001]}; // RL9
    endfunction

    // =====================================================================
    // decode of the stored frame
    assign fc      = buf_mem[1];
    assign cnt     = buf_mem[6];
    assign start   = word_at(9'h002);
    assign num     = word_at(9'h004);
    // running checksum over frame plus its low-first checksum leaves zero
    assign crc_ok  = (rx_crc == `MBR_CRC_RESID); // RL9 RL10
    assign fc_ok   = fc inside {`MBR_FC_RC, `READ_REGS_CMD, `WRITE_COIL_CMD,
                                `WRITE_REG_CMD, `WRITE_REGS_CMD}; // RL4
    assign is_wr   = fc inside {`WRITE_COIL_CMD, `WRITE_REG_CMD, `WRITE_REGS_CMD};
    assign rx_take = rx_valid_in && rx_ready_r;

    always_comb begin
        exec_err = `MBR_ERR_NONE;
        if (!crc_ok) begin
            exec_err = `MBR_ERR_CRC; // RL10
        end else if (!fc_ok) begin
            exec_err = `MBR_ERR_FUNC; // RL4
        end else if (fc == `MBR_FC_RC && num != 16'h0001) begin
            exec_err = `MBR_ERR_DATA; // RL12
        end else if (fc == `READ_REGS_CMD && (num == 16'h0000 || num > `MBR_MAX_RD)) begin
            exec_err = `MBR_ERR_DATA;
        end else if (fc == `WRITE_COIL_CMD
                     && num != `MBR_COIL_FALSE && num != `MBR_COIL_TRUE) begin
            exec_err = `MBR_ERR_DATA; // RL6
        end else if (fc == `WRITE_REGS_CMD && (num == 16'h0000 || num > `MBR_MAX_WR
                     || {8'h00, cnt} != {num[14:0], 1'b0})) begin
            exec_err = `MBR_ERR_DATA; // RL8
        end else if (is_wr && !remote_in) begin
            exec_err = `MBR_ERR_ACCESS; // RL18
        end
    end

    // =====================================================================
    // answer byte: zero, function, content, then checksum
    always_comb begin
        tx_byte = buf_mem[tidx_r]; // RL3 RL14 RL15
        if (state_r == ST_CRCL) begin
            tx_byte = tx_crc[7:0]; // RL9
        end else if (state_r == ST_CRCH) begin
            tx_byte = tx_crc[15:8];
        end else if (tidx_r == 9'h000) begin
            tx_byte = `MBR_ADDR_BYTE; // RL1 RL13
        end else if (err_r != `MBR_ERR_NONE) begin
            tx_byte = (tidx_r == 9'h001) ? (fc | `MBR_FC_ERR) : err_r; // RL17
        end else if (fc == `MBR_FC_RC) begin
            case (tidx_r)
                9'h001:  tx_byte = fc;
                9'h002:  tx_byte = 8'h02; // RL12
                9'h003:  tx_byte = coil_state_in ? 8'(`MBR_COIL_TRUE >> 8) : 8'h00; // RL5
                default: tx_byte = 8'h00;
            endcase
        end else if (fc == `READ_REGS_CMD) begin
            case (tidx_r)
                9'h001:  tx_byte = fc;
                9'h002:  tx_byte = {num[6:0], 1'b0}; // RL11
                default: tx_byte = ph_r ? reg_rdata_in[7:0] : reg_rdata_in[15:8];
            endcase
        end
    end

    // =====================================================================
    // sequencer
    always_comb begin
        state_nxt      = state_r;
        idx_nxt        = idx_r;
        len_nxt        = len_r;
        tidx_nxt       = tidx_r;
        tlen_nxt       = tlen_r;
        err_nxt        = err_r;
        k_nxt          = k_r;
        ph_nxt         = ph_r;
        rx_ready_nxt   = rx_ready_r;
        text_valid_nxt = 1'b0;
        text_data_nxt  = text_data_r;
        reg_addr_nxt   = reg_addr_r;
        reg_wdata_nxt  = reg_wdata_r;
        reg_wr_nxt     = 1'b0;
        reg_coil_nxt   = reg_coil_r;
        rx_crc_init    = 1'b0;
        rx_crc_en      = 1'b0;
        tx_crc_init    = 1'b0;
        tx_crc_en      = 1'b0;
        push_if.valid  = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (rx_take && rx_data_in == `MBR_ADDR_BYTE) begin
                    rx_crc_init = 1'b1; // RL1 RL2
                    idx_nxt     = 9'h001;
                    len_nxt     = `MBR_LEN_OPEN;
                    state_nxt   = ST_RECV;
                end else if (rx_take) begin
                    text_valid_nxt = 1'b1; // RL2
                    text_data_nxt  = rx_data_in;
                    if (rx_data_in != `MBR_TEXT_END) begin
                        state_nxt = ST_TEXT;
                    end
                end
            end
            ST_TEXT: begin
                if (rx_take) begin
                    text_valid_nxt = 1'b1; // RL2
                    text_data_nxt  = rx_data_in;
                    if (rx_data_in == `MBR_TEXT_END) begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_RECV: begin
                if (rx_take) begin
                    rx_crc_en = 1'b1;
                    idx_nxt   = idx_r + 9'h001;
                    if (idx_r == 9'h001) begin
                        // unknown codes are taken as eight bytes and refused later
                        len_nxt = (rx_data_in == `WRITE_REGS_CMD) ? `MBR_LEN_OPEN
                                                               : `MBR_FIX_LEN; // RL7 RL19
                    end else if (idx_r == 9'h006 && fc == `WRITE_REGS_CMD) begin
                        len_nxt = `MBR_WR_HDR + {1'b0, rx_data_in}; // RL8 RL19
                    end else if (idx_r + 9'h001 == len_r) begin
                        rx_ready_nxt = 1'b0; // RL10 RL19
                        state_nxt    = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                err_nxt      = exec_err;
                tidx_nxt     = 9'h000;
                k_nxt        = 8'h00;
                ph_nxt       = 1'b0;
                reg_addr_nxt = start;
                reg_coil_nxt = (fc == `MBR_FC_RC) || (fc == `WRITE_COIL_CMD);
                tlen_nxt     = 9'h006; // RL14 RL15
                state_nxt    = ST_SEND;
                if (exec_err != `MBR_ERR_NONE) begin
                    tlen_nxt = 9'h003; // RL17
                end else if (fc == `MBR_FC_RC) begin
                    tlen_nxt = 9'h005; // RL5 RL12
                end else if (fc == `READ_REGS_CMD) begin
                    tlen_nxt = 9'h003 + {num[7:0], 1'b0}; // RL11
                end else if (fc == `WRITE_REGS_CMD) begin
                    state_nxt = ST_WRITE;
                end else begin
                    reg_wr_nxt    = 1'b1; // RL3
                    reg_wdata_nxt = num;
                end
            end
            ST_WRITE: begin
                reg_wr_nxt    = 1'b1; // RL8
                reg_addr_nxt  = start + {8'h00, k_r};
                reg_wdata_nxt = word_at(9'h007 + {k_r, 1'b0});
                k_nxt         = k_r + 8'h01;
                if (k_r + 8'h01 == num[7:0]) begin
                    state_nxt = ST_SEND;
                end
            end
            ST_SEND: begin
                push_if.valid = 1'b1;
                if (push_if.ready) begin
                    tx_crc_en   = 1'b1;
                    tx_crc_init = (tidx_r == 9'h000);
                    tidx_nxt    = tidx_r + 9'h001;
                    if (fc == `READ_REGS_CMD && tidx_r >= 9'h003) begin
                        ph_nxt = ~ph_r;
                        if (ph_r) begin
                            reg_addr_nxt = reg_addr_r + 16'h0001;
                        end
                    end
                    if (tidx_r + 9'h001 == tlen_r) begin
                        state_nxt = ST_CRCL;
                    end
                end
            end
            ST_CRCL: begin
                push_if.valid = 1'b1;
                if (push_if.ready) begin
                    state_nxt = ST_CRCH;
                end
            end
            ST_CRCH: begin
                push_if.valid = 1'b1;
                if (push_if.ready) begin
                    rx_ready_nxt = 1'b1;
                    state_nxt    = ST_IDLE;
                end
            end
            default: begin
                rx_ready_nxt = 1'b1;
                state_nxt    = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r      <= ST_IDLE;
            idx_r        <= '0;
            len_r        <= `MBR_LEN_OPEN;
            tidx_r       <= '0;
            tlen_r       <= '0;
            err_r        <= `MBR_ERR_NONE;
            k_r          <= '0;
            ph_r         <= 1'b0;
            rx_ready_r   <= 1'b1;
            text_valid_r <= 1'b0;
            text_data_r  <= '0;
            reg_addr_r   <= '0;
            reg_wdata_r  <= '0;
            reg_wr_r     <= 1'b0;
            reg_coil_r   <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            idx_r        <= idx_nxt;
            len_r        <= len_nxt;
            tidx_r       <= tidx_nxt;
            tlen_r       <= tlen_nxt;
            err_r        <= err_nxt;
            k_r          <= k_nxt;
            ph_r         <= ph_nxt;
            rx_ready_r   <= rx_ready_nxt;
            text_valid_r <= text_valid_nxt;
            text_data_r  <= text_data_nxt;
            reg_addr_r   <= reg_addr_nxt;
            reg_wdata_r  <= reg_wdata_nxt;
            reg_wr_r     <= reg_wr_nxt;
            reg_coil_r   <= reg_coil_nxt;
        end
    end

    // frame store has no reset; only bytes of the current frame are read
    always_ff @(posedge clk_in) begin
        if (rx_take && (state_r == ST_IDLE || state_r == ST_RECV)) begin
            buf_mem[(state_r == ST_IDLE) ? 9'h000 : idx_r] <= rx_data_in;
        end
    end

    // =====================================================================
    // checksums and answer queue
    mbr_crc u_rx_crc (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .init_in  (rx_crc_init),
        .en_in    (rx_crc_en),
        .data_in  (rx_data_in),
        .crc_out  (rx_crc)
    );

    mbr_crc u_tx_crc (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .init_in  (tx_crc_init),
        .en_in    (tx_crc_en && !tx_crc_init),
        .data_in  (tx_byte),
        .crc_out  (tx_crc)
    );

    // a full queue stalls the answer, which holds off the next frame
    mbr_fifo #(.W(8), .D(`MBR_FIFO_DEPTH)) u_fifo (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .in_if    (push_if),
        .out_if   (pop_if)
    );

    assign push_if.data   = tx_byte;
    assign push_fire      = push_if.valid && push_if.ready;
    assign pop_if.ready   = tx_ready_in;
    assign tx_valid_out   = pop_if.valid;
    assign tx_data_out    = pop_if.data;
    assign rx_ready_out   = rx_ready_r;
    assign text_valid_out = text_valid_r;
    assign text_data_out  = text_data_r;
    assign reg_addr_out   = reg_addr_r;
    assign reg_wdata_out  = reg_wdata_r;
    assign reg_wr_out     = reg_wr_r;
    assign reg_coil_out   = reg_coil_r;

    // =====================================================================
    // checks
    a_frame_zero: // RL1
    assert property (push_fire && state_r == ST_SEND && tidx_r == 9'h000
                     |-> push_if.data == `MBR_ADDR_BYTE) else $error("answer lacks zero address");
    a_text_route: // RL2
    assert property (rx_take && state_r == ST_IDLE && rx_data_in != `MBR_ADDR_BYTE
                     |=> text_valid_r && text_data_r == $past(rx_data_in))
        else $error("text byte not routed");
    a_bad_func: // RL4
    assert property (state_r == ST_EXEC && crc_ok && !fc_ok |=> err_r == `MBR_ERR_FUNC)
        else $error("unknown function not refused");
    a_crc_reject: // RL10
    assert property (state_r == ST_EXEC && !crc_ok
                     |=> err_r == `MBR_ERR_CRC && tlen_r == 9'h003 && !reg_wr_r)
        else $error("bad checksum not refused");
    a_read_len: // RL11
    assert property (state_r == ST_EXEC && exec_err == `MBR_ERR_NONE && fc == `READ_REGS_CMD
                     |=> tlen_r == 9'h003 + {num[7:0], 1'b0}) else $error("read length wrong");
    a_coil_len: // RL12
    assert property (state_r == ST_EXEC && exec_err == `MBR_ERR_NONE && fc == `MBR_FC_RC
                     |=> tlen_r == 9'h005 ##1 state_r == ST_SEND) else $error("coil length wrong");
    a_echo_write: // RL14
    assert property (state_r == ST_EXEC && exec_err == `MBR_ERR_NONE
                     && (fc == `WRITE_COIL_CMD || fc == `WRITE_REG_CMD)
                     |=> reg_wr_r && reg_wdata_r == num && tlen_r == 9'h006)
        else $error("single write not echoed");
    a_err_code: // RL17
    assert property (push_fire && state_r == ST_SEND && tidx_r == 9'h001 && err_r != 8'h00
                     |-> push_if.data == (fc | `MBR_FC_ERR)) else $error("error code byte wrong");
    a_remote_gate: // RL18
    assert property (state_r == ST_EXEC && crc_ok && is_wr && !remote_in
                     |=> !reg_wr_r && state_r == ST_SEND) else $error("write without remote");

    c_err_resp: cover property (state_r == ST_EXEC && exec_err != `MBR_ERR_NONE);
    c_read_regs: cover property (state_r == ST_SEND && fc == `READ_REGS_CMD && tidx_r > 9'h004);
    c_multi_write: cover property (state_r == ST_WRITE ##1 state_r == ST_WRITE);
    c_fifo_full: cover property (push_if.valid && !push_if.ready);
endmodule // mbr_frame_handler
`default_nettype wire

// file: rtl/mbr_pkg.sv
/*
 * Types of the binary frame handler.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package mbr_pkg;
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_TEXT  = 8'h02,
        ST_RECV  = 8'h04,
        ST_EXEC  = 8'h08,
        ST_WRITE = 8'h10,
        ST_SEND  = 8'h20,
        ST_CRCL  = 8'h40,
        ST_CRCH  = 8'h80
    } mbr_state_type;
endpackage
`default_nettype wire

// file: rtl/mbr_regs.svh
/*
 * Constants of the binary frame handler: frame bytes, function codes, error
 * codes, checksum values and length figures.
 * Assumes it is included by bare name from every file that needs one of them.
 */
// Behaviour
// [RL1] every binary frame starts with address zero
// [RL2] zero first byte means binary, else text
// [RL3] queries get data, writes get echo only
// [RL4] decode function byte: 01, 03, 05, 06, 10
// [RL5] coil read returns one word, FF00 true
// [RL6] coil write data word 0000 or FF00
// [RL7] single register write frame is eight bytes
// [RL8] byte count equals twice register count
// [RL9] fields high byte first, checksum low first
// [RL10] checksum position fixed, wrong length fails it
// [RL11] register read returns two bytes each
// [RL12] coil read count one, two data bytes
// [RL13] answer at once: zero, function, content, checksum
// [RL14] single writes echo function, register, value
// [RL15] multi write echoes start and count
// [RL16] reflected checksum, seed FFFF, polynomial A001
// [RL17] errors answer function plus 80, code
// [RL18] writes refused unless remote control active
// [RL19] frame end from function and byte count
`ifndef MBR_REGS_SVH
`define MBR_REGS_SVH

// =====================================================================
// frame layout
`define MBR_ADDR_BYTE   8'h00
`define MBR_TEXT_END    8'h0A
`define MBR_FIX_LEN     9'h008
`define MBR_WR_HDR      9'h009
`define MBR_LEN_OPEN    9'h108
`define MBR_BUF_DEPTH   264
`define MBR_MAX_RD      16'h007D
`define MBR_MAX_WR      16'h007B

// =====================================================================
// function codes
`define MBR_FC_RC       8'h01
`define READ_REGS_CMD   8'h03
`define WRITE_COIL_CMD  8'h05
`define WRITE_REG_CMD   8'h06
`define WRITE_REGS_CMD  8'h10
`define MBR_FC_ERR      8'h80

// =====================================================================
// error codes
`define MBR_ERR_NONE    8'h00
`define MBR_ERR_FUNC    8'h01
`define MBR_ERR_DATA    8'h03
`define MBR_ERR_CRC     8'h05
`define MBR_ERR_ACCESS  8'h07

// =====================================================================
// coil words, checksum and answer queue depth
`define MBR_COIL_TRUE   16'hFF00
`define MBR_COIL_FALSE  16'h0000
`define MBR_CRC_INIT    16'hFFFF
`define MBR_CRC_POLY    16'hA001
`define MBR_CRC_RESID   16'h0000
`define MBR_FIFO_DEPTH  16

`endif

// file: rtl/mbr_strm_if.sv
/*
 * Byte stream with valid and ready between the handler and its FIFO.
 * Assumes a transfer happens on a clock edge with valid and ready both high.
 */
`default_nettype none
interface mbr_strm_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire
